// [hdl/mrf_rx_filter.sv]
// receive filter, vlan recognition and half-duplex back-pressure of a 10/100 mac
`timescale 1ns/10ps

module mrf_rx_filter
  import mrf_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH,
  parameter int LVL_W = RX_FIFO_LVL_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  // configuration
  input wire logic half_duplex,
  input wire logic [LVL_W-1:0] bp_threshold,
  input wire mrf_filter_ctrl_t filter_ctrl,
  input wire logic [47:0] station_addr,
  input wire logic [31:0] hash_table_low,
  input wire logic [31:0] hash_table_high,
  input wire logic [15:0] vlan_tag_one,
  input wire logic [15:0] vlan_tag_two,
  // receive byte stream from the phy side
  input wire logic rx_carrier,
  input wire logic rx_byte_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic [7:0] rx_byte,
  // transmit byte stream watched for vlan tags
  input wire logic tx_busy,
  input wire logic tx_byte_valid,
  input wire logic tx_sof,
  input wire logic [7:0] tx_byte,
  // jam request to the transmitter
  output logic jam_active,
  // frame status
  output mrf_vlan_t rx_vlan_level,
  output logic [BYTE_CNT_W-1:0] rx_max_len,
  output mrf_vlan_t tx_vlan_level,
  output logic [BYTE_CNT_W-1:0] tx_max_len,
  output logic rx_frame_rejected,
  // receive fifo output towards the host side
  output logic rx_out_valid,
  output mrf_rx_word_t rx_out_word,
  input wire logic rx_out_ready
);

  // one crc step over a byte, bit 0 first as it goes on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] crc_in, input logic [7:0] d);
    logic [31:0] c;
    logic fb;
    c = crc_in;
    for (int i = 0; i < 8; i++) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
    end
    return c;
  endfunction : crc_byte

  // tag lookup shared by the receive and transmit paths
  function automatic mrf_vlan_t vlan_match(input logic [15:0] tag, input logic [15:0] t1,
                                           input logic [15:0] t2);
    mrf_vlan_t v;
    v = MRF_VLAN_NONE;
    if (tag == t1) begin
      v = MRF_VLAN_ONE;
    end else if (tag == t2) begin
      v = MRF_VLAN_TWO;
    end
    return v;
  endfunction : vlan_match

  function automatic logic [BYTE_CNT_W-1:0] max_len_of(input mrf_vlan_t v);
    return (v == MRF_VLAN_NONE) ? MAX_LEN_PLAIN : MAX_LEN_VLAN;
  endfunction : max_len_of

  // address filter decision from the five controls
  function automatic logic filter_pass(input mrf_filter_ctrl_t c, input logic is_mc,
                                       input logic perfect, input logic hash_hit);
    logic p;
    p = perfect;
    if (c.promiscuous_enable && !c.inverse_filter_enable) begin
      p = 1'b1;
    end else if (c.inverse_filter_enable && !c.promiscuous_enable && !c.pass_all_multicast
                 && !c.hash_only_enable && !c.hash_perfect_enable) begin
      p = !perfect;
    end else if (c.inverse_filter_enable || c.promiscuous_enable) begin
      p = perfect;
    end else if (c.pass_all_multicast && is_mc) begin
      p = 1'b1;
    end else if (c.hash_only_enable && c.hash_perfect_enable) begin
      p = hash_hit;
    end else if (!c.hash_only_enable && c.hash_perfect_enable && !c.pass_all_multicast) begin
      p = is_mc ? hash_hit : perfect;
    end else if (!c.hash_only_enable) begin
      p = perfect;
    end
    return p;
  endfunction : filter_pass

  // ---------------- receive frame tracking ----------------
  logic [BYTE_CNT_W-1:0] rx_cnt_reg;
  logic [47:0] da_reg;
  logic [31:0] crc_reg;
  logic [7:0] vlan_hi_reg;
  logic da_done_reg;
  logic pass_reg;
  logic oversize_reg;
  logic overrun_reg;
  logic rx_in_frame_reg;
  mrf_vlan_t rx_vlan_reg;
  logic [BYTE_CNT_W-1:0] rx_max_len_reg;
  logic rx_rejected_reg;

  logic [BYTE_CNT_W-1:0] rx_cnt_cur;
  logic [BYTE_CNT_W-1:0] rx_cnt_after;
  logic [47:0] da_next;
  logic [31:0] crc_next;
  logic [5:0] hash_idx;
  logic hash_hit;
  logic perfect_hit;
  logic is_mc;
  logic pass_now;
  logic oversize_now;
  logic frame_good;
  logic byte_take;

  logic fifo_s_ready;
  logic [LVL_W-1:0] fifo_level;
  mrf_rx_word_t push_word;
  logic push_valid;

  // a start byte restarts the count even if the previous frame lost its end
  assign byte_take = rx_byte_valid;
  assign rx_cnt_cur = rx_sof ? '0 : rx_cnt_reg;
  assign rx_cnt_after = (rx_cnt_cur == BYTE_CNT_MAX) ? BYTE_CNT_MAX : rx_cnt_cur + 1'b1;

  always_comb begin
    da_next = rx_sof ? 48'h0000_0000_0000 : da_reg;
    crc_next = crc_byte(rx_sof ? CRC_INIT : crc_reg, rx_byte);
    if (rx_cnt_cur <= DA_LAST_IDX) begin
      da_next[8*rx_cnt_cur[2:0] +: 8] = rx_byte;
    end
  end

  assign hash_idx = crc_next[HASH_IDX_MSB:HASH_IDX_LSB];
  // table bit 0..31 in the low word, 32..63 in the high word
  assign hash_hit = hash_idx[5] ? hash_table_high[hash_idx[4:0]]
                                : hash_table_low[hash_idx[4:0]];
  assign perfect_hit = (da_next == station_addr);
  assign is_mc = da_next[0];
  assign pass_now = filter_pass(filter_ctrl, is_mc, perfect_hit, hash_hit);
  assign oversize_now = oversize_reg || (rx_cnt_after > rx_max_len_reg);

  // a frame of two to six bytes never finishes its address and is never good; a one-byte frame is judged on the previous frame's flags
  assign frame_good = da_done_reg && pass_reg && !oversize_now && !overrun_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_reg <= '0;
      da_reg <= '0;
      crc_reg <= CRC_INIT;
      da_done_reg <= 1'b0;
      pass_reg <= 1'b0;
      rx_in_frame_reg <= 1'b0;
    end else if (byte_take) begin
      rx_cnt_reg <= rx_cnt_after;
      da_reg <= da_next;
      crc_reg <= crc_next;
      rx_in_frame_reg <= !rx_eof;
      if (rx_sof) begin
        da_done_reg <= 1'b0;
        pass_reg <= 1'b0;
      end
      if (rx_cnt_cur == DA_LAST_IDX) begin
        da_done_reg <= 1'b1;
        pass_reg <= pass_now;
      end
    end
  end

  // vlan tag capture and per-frame length limit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vlan_hi_reg <= '0;
      rx_vlan_reg <= MRF_VLAN_NONE;
      rx_max_len_reg <= MAX_LEN_PLAIN;
    end else if (byte_take) begin
      if (rx_sof) begin
        rx_vlan_reg <= MRF_VLAN_NONE;
        rx_max_len_reg <= MAX_LEN_PLAIN;
      end
      if (rx_cnt_cur == VLAN_HI_IDX) begin
        vlan_hi_reg <= rx_byte;
      end
      if (rx_cnt_cur == VLAN_LO_IDX) begin
        rx_vlan_reg <= vlan_match({vlan_hi_reg, rx_byte}, vlan_tag_one, vlan_tag_two);
        rx_max_len_reg <= max_len_of(vlan_match({vlan_hi_reg, rx_byte}, vlan_tag_one,
                                                vlan_tag_two));
      end
    end
  end

  // length and overrun errors stick until the next start byte
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      oversize_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else if (byte_take) begin
      oversize_reg <= rx_sof ? 1'b0 : oversize_now;
      // the phy cannot be stalled, so a byte with no room spoils the frame
      overrun_reg <= (rx_sof ? 1'b0 : overrun_reg) || !fifo_s_ready;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rx_rejected_reg <= 1'b0;
    end else begin
      rx_rejected_reg <= byte_take && rx_eof && !frame_good;
    end
  end

  // the closing word carries the verdict; an overrun frame stops pushing
  assign push_valid = byte_take && !(overrun_reg && !rx_sof);
  assign push_word = '{data: rx_byte, last: rx_eof, good: rx_eof && frame_good};

  mrf_fifo #(
    .WIDTH($bits(mrf_rx_word_t)),
    .DEPTH(FIFO_DEPTH),
    .LW(LVL_W)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .s_valid(push_valid),
    .s_data(push_word),
    .s_ready(fifo_s_ready),
    .m_valid(rx_out_valid),
    .m_data(rx_out_word),
    .m_ready(rx_out_ready),
    .level(fifo_level)
  );

  // ---------------- transmit vlan recognition ----------------
  logic [3:0] tx_cnt_reg;
  logic [7:0] tx_hi_reg;
  mrf_vlan_t tx_vlan_reg;
  logic [BYTE_CNT_W-1:0] tx_max_len_reg;
  logic [3:0] tx_cnt_cur;

  assign tx_cnt_cur = tx_sof ? 4'h0 : tx_cnt_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tx_cnt_reg <= '0;
      tx_hi_reg <= '0;
      tx_vlan_reg <= MRF_VLAN_NONE;
      tx_max_len_reg <= MAX_LEN_PLAIN;
    end else if (tx_byte_valid) begin
      // saturates past the tag bytes; only bytes 12 and 13 matter here
      tx_cnt_reg <= (tx_cnt_cur == 4'hF) ? 4'hF : tx_cnt_cur + 1'b1;
      if (tx_sof) begin
        tx_vlan_reg <= MRF_VLAN_NONE;
        tx_max_len_reg <= MAX_LEN_PLAIN;
      end
      if (tx_cnt_cur == VLAN_HI_IDX[3:0]) begin
        tx_hi_reg <= tx_byte;
      end
      if (tx_cnt_cur == VLAN_LO_IDX[3:0]) begin
        tx_vlan_reg <= vlan_match({tx_hi_reg, tx_byte}, vlan_tag_one, vlan_tag_two);
        tx_max_len_reg <= max_len_of(vlan_match({tx_hi_reg, tx_byte}, vlan_tag_one,
                                                vlan_tag_two));
      end
    end
  end

  // ---------------- half-duplex back pressure ----------------
  mrf_bp_state_t bp_state_reg;
  mrf_bp_state_t bp_state_next;
  logic bp_request;
  logic jam_reg;
  logic rx_new_frame;

  assign bp_request = half_duplex && (!fifo_s_ready || fifo_level >= bp_threshold);
  // only a start byte counts, so a frame already running is never jammed
  assign rx_new_frame = rx_byte_valid && rx_sof;

  always_comb begin
    bp_state_next = bp_state_reg;
    case (bp_state_reg)
      MRF_BP_IDLE: begin
        if (bp_request) begin
          bp_state_next = tx_busy ? MRF_BP_TX_DRAIN : MRF_BP_WAIT_SOF;
        end
      end
      MRF_BP_TX_DRAIN: begin
        if (!half_duplex) begin
          bp_state_next = MRF_BP_IDLE;
        end else if (!tx_busy) begin
          bp_state_next = MRF_BP_WAIT_SOF;
        end
      end
      MRF_BP_WAIT_SOF: begin
        if (!bp_request) begin
          bp_state_next = MRF_BP_IDLE;
        end else if (rx_new_frame) begin
          bp_state_next = MRF_BP_JAM;
        end
      end
      MRF_BP_JAM: begin
        // jam lasts for the whole carrier so other stations defer
        if (!half_duplex) begin
          bp_state_next = MRF_BP_IDLE;
        end else if (!rx_carrier) begin
          bp_state_next = bp_request ? MRF_BP_WAIT_SOF : MRF_BP_IDLE;
        end
      end
      default: begin
        bp_state_next = MRF_BP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bp_state_reg <= MRF_BP_IDLE;
      jam_reg <= RST_JAM;
    end else begin
      bp_state_reg <= bp_state_next;
      jam_reg <= (bp_state_next == MRF_BP_JAM);
    end
  end

  assign jam_active = jam_reg;
  assign rx_vlan_level = rx_vlan_reg;
  assign rx_max_len = rx_max_len_reg;
  assign tx_vlan_level = tx_vlan_reg;
  assign tx_max_len = tx_max_len_reg;
  assign rx_frame_rejected = rx_rejected_reg;

endmodule : mrf_rx_filter

// [hdl/mrf_pkg.sv]
// shared constants, types and states for the mac receive filter block
package mrf_pkg;

  // byte positions inside a frame, counted from zero at the first da byte
  localparam int BYTE_CNT_W = 11;
  localparam logic [BYTE_CNT_W-1:0] DA_LAST_IDX = 11'h005;
  localparam logic [BYTE_CNT_W-1:0] VLAN_HI_IDX = 11'h00C;
  localparam logic [BYTE_CNT_W-1:0] VLAN_LO_IDX = 11'h00D;
  localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_MAX = 11'h7FF;

  // good frame length limits, fcs included
  localparam logic [BYTE_CNT_W-1:0] MAX_LEN_PLAIN = 11'd1518;
  localparam logic [BYTE_CNT_W-1:0] MAX_LEN_VLAN = 11'd1522;

  // hash crc: msb-first register, wire-order data bits, no final inversion
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam int HASH_IDX_MSB = 31;
  localparam int HASH_IDX_LSB = 26;

  // receive fifo defaults
  localparam int RX_FIFO_DEPTH = 8;
  localparam int RX_FIFO_LVL_W = 4;

  // reset value of the jam request output
  localparam logic RST_JAM = 1'b0;

  typedef struct packed {
    logic pass_all_multicast;
    logic promiscuous_enable;
    logic inverse_filter_enable;
    logic hash_only_enable;
    logic hash_perfect_enable;
  } mrf_filter_ctrl_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic good;
  } mrf_rx_word_t;

  typedef enum logic [1:0] {
    MRF_VLAN_NONE = 2'b00,
    MRF_VLAN_ONE = 2'b01,
    MRF_VLAN_TWO = 2'b10
  } mrf_vlan_t;

  typedef enum logic [1:0] {
    MRF_BP_IDLE = 2'b00,
    MRF_BP_TX_DRAIN = 2'b01,
    MRF_BP_WAIT_SOF = 2'b10,
    MRF_BP_JAM = 2'b11
  } mrf_bp_state_t;

endpackage : mrf_pkg

// [hdl/mrf_fifo.sv]
// receive fifo with registered head word and fill level
`timescale 1ns/10ps
module mrf_fifo
  import mrf_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = RX_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int LW = RX_FIFO_LVL_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic s_valid,
  input wire logic [WIDTH-1:0] s_data,
  output logic s_ready,
  output logic m_valid,
  output logic [WIDTH-1:0] m_data,
  input wire logic m_ready,
  output logic [LW-1:0] level
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic m_valid_reg;
  logic [WIDTH-1:0] m_data_reg;
  logic push;
  logic load;

  assign s_ready = (count_reg != (AW+1)'(DEPTH));
  assign push = s_valid && s_ready;
  // head register refills whenever it is empty or being taken
  assign load = (count_reg != '0) && (!m_valid_reg || m_ready);
  assign m_valid = m_valid_reg;
  assign m_data = m_data_reg;
  assign level = LW'(count_reg) + LW'(m_valid_reg);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= s_data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (load) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      m_valid_reg <= 1'b0;
      m_data_reg <= '0;
    end else if (load) begin
      m_valid_reg <= 1'b1;
      m_data_reg <= mem[rd_ptr_reg];
    end else if (m_ready) begin
      m_valid_reg <= 1'b0;
    end
  end

endmodule : mrf_fifo

// [tb/mrf_rx_filter_sva.sv]
// port checker for the receive filter block, bound into every instance
`timescale 1ns/10ps
module mrf_rx_filter_sva
  import mrf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic half_duplex,
  input wire logic rx_carrier,
  input wire logic rx_byte_valid,
  input wire logic rx_sof,
  input wire logic rx_eof,
  input wire logic jam_active,
  input wire mrf_vlan_t rx_vlan_level,
  input wire logic [BYTE_CNT_W-1:0] rx_max_len,
  input wire mrf_vlan_t tx_vlan_level,
  input wire logic [BYTE_CNT_W-1:0] tx_max_len,
  input wire logic rx_frame_rejected,
  input wire logic rx_out_valid,
  input wire mrf_rx_word_t rx_out_word,
  input wire logic rx_out_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  chk_jam_at_sof: assert property (
    $rose(jam_active) |-> $past(rx_byte_valid && rx_sof && half_duplex))
    else $error("jam started without a new frame");
  chk_jam_holds: assert property (
    jam_active && rx_carrier && half_duplex |=> jam_active)
    else $error("jam dropped while carrier present");
  chk_jam_ends: assert property (jam_active && !rx_carrier |=> !jam_active)
    else $error("jam kept after carrier dropped");
  chk_full_duplex_quiet: assert property (!half_duplex |=> !jam_active)
    else $error("jam in full duplex");
  chk_rx_len_limit: assert property (
    rx_max_len == ((rx_vlan_level == MRF_VLAN_NONE) ? MAX_LEN_PLAIN : MAX_LEN_VLAN))
    else $error("rx length limit does not follow tag level");
  chk_tx_len_limit: assert property (
    tx_max_len == ((tx_vlan_level == MRF_VLAN_NONE) ? MAX_LEN_PLAIN : MAX_LEN_VLAN))
    else $error("tx length limit does not follow tag level");
  chk_vlan_clear_sof: assert property (
    rx_byte_valid && rx_sof |=> rx_vlan_level == MRF_VLAN_NONE)
    else $error("tag level not cleared at frame start");
  chk_reject_cause: assert property (
    rx_frame_rejected |-> $past(rx_byte_valid && rx_eof))
    else $error("reject pulse without frame end");
  chk_reject_pulse: assert property (rx_frame_rejected |=> !rx_frame_rejected)
    else $error("reject pulse longer than one cycle");
  chk_head_stands: assert property (
    rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out_word))
    else $error("fifo head changed while stalled");
  cov_jam: cover property ($rose(jam_active));
  cov_two_level: cover property (rx_vlan_level == MRF_VLAN_TWO);
  cov_reject: cover property (rx_frame_rejected);
endmodule : mrf_rx_filter_sva

bind mrf_rx_filter mrf_rx_filter_sva u_sva (.clk_sys(clk_sys), .nrst(nrst),
  .half_duplex(half_duplex),
  .rx_carrier(rx_carrier), .rx_byte_valid(rx_byte_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
  .jam_active(jam_active), .rx_vlan_level(rx_vlan_level), .rx_max_len(rx_max_len),
  .tx_vlan_level(tx_vlan_level), .tx_max_len(tx_max_len), .rx_frame_rejected(rx_frame_rejected),
  .rx_out_valid(rx_out_valid), .rx_out_word(rx_out_word), .rx_out_ready(rx_out_ready));

// [tb/mrf_phy_model.sv]
// remote station seen through the phy: sends received frames byte by byte
`timescale 1ns/10ps
module mrf_phy_model (
  input wire logic clk_sys,
  output logic rx_carrier,
  output logic rx_byte_valid,
  output logic rx_sof,
  output logic rx_eof,
  output logic [7:0] rx_byte
);
  logic [7:0] frm [0:1535];
  initial begin
    rx_carrier = 1'b0;
    rx_byte_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_byte = 8'h00;
  end
  // the phy cannot stall, so bytes go out every cycle; carrier may be kept up to hold a jam
  task automatic send(input int len, input bit hold);
    for (int i = 0; i < len; i++) begin
      @(negedge clk_sys);
      rx_carrier = 1'b1;
      rx_byte_valid = 1'b1;
      rx_sof = (i == 0);
      rx_eof = (i == len - 1);
      rx_byte = frm[i];
    end
    @(negedge clk_sys);
    rx_byte_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    // stale data is not left on the bus after the last byte
    rx_byte = ~rx_byte;
    rx_carrier = hold;
  endtask : send
  task automatic drop();
    @(negedge clk_sys);
    rx_carrier = 1'b0;
  endtask : drop
endmodule : mrf_phy_model

// [tb/mrf_rx_filter_tb_top.sv]
// self-checking bench for address filter, tag recognition and back pressure
`timescale 1ns/10ps
module mrf_rx_filter_tb_top;
  import mrf_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic half_duplex = 1'b0;
  logic [3:0] bp_threshold = 4'h2;
  mrf_filter_ctrl_t filter_ctrl = '0;
  logic [47:0] station_addr = 48'h5544_3322_1100;
  logic [31:0] hash_table_low, hash_table_high;
  logic [15:0] vlan_tag_one = 16'h8100;
  logic [15:0] vlan_tag_two = 16'h9100;
  logic rx_carrier, rx_byte_valid, rx_sof, rx_eof, jam_active, rx_frame_rejected, rx_out_valid;
  logic [7:0] rx_byte;
  logic tx_busy = 1'b0, tx_byte_valid = 1'b0, tx_sof = 1'b0, rx_out_ready = 1'b1;
  logic [7:0] tx_byte = 8'h00;
  mrf_vlan_t rx_vlan_level, tx_vlan_level;
  logic [BYTE_CNT_W-1:0] rx_max_len, tx_max_len;
  mrf_rx_word_t rx_out_word;
  int num_errors = 0;
  int compares = 0;
  int frames = 0;
  int rejects = 0;
  logic last_good;
  logic [4:0] modes [0:10];
  logic [47:0] das [0:3];
  logic [15:0] tags [0:2];
  always #10 clk_sys = ~clk_sys;
  mrf_phy_model phy (.clk_sys(clk_sys), .rx_carrier(rx_carrier), .rx_byte_valid(rx_byte_valid),
    .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_byte(rx_byte));
  mrf_rx_filter uut (.clk_sys(clk_sys), .nrst(nrst), .half_duplex(half_duplex),
    .bp_threshold(bp_threshold), .filter_ctrl(filter_ctrl), .station_addr(station_addr),
    .hash_table_low(hash_table_low), .hash_table_high(hash_table_high),
    .vlan_tag_one(vlan_tag_one), .vlan_tag_two(vlan_tag_two), .rx_carrier(rx_carrier),
    .rx_byte_valid(rx_byte_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_byte(rx_byte),
    .tx_busy(tx_busy), .tx_byte_valid(tx_byte_valid), .tx_sof(tx_sof), .tx_byte(tx_byte),
    .jam_active(jam_active), .rx_vlan_level(rx_vlan_level), .rx_max_len(rx_max_len),
    .tx_vlan_level(tx_vlan_level), .tx_max_len(tx_max_len),
    .rx_frame_rejected(rx_frame_rejected), .rx_out_valid(rx_out_valid),
    .rx_out_word(rx_out_word), .rx_out_ready(rx_out_ready));
  always @(posedge clk_sys) begin
    if (rx_out_valid && rx_out_ready && rx_out_word.last) begin
      last_good <= rx_out_word.good;
      frames <= frames + 1;
    end
    if (rx_frame_rejected) begin
      rejects <= rejects + 1;
    end
  end
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // wire-order crc, upper six bits form the table index
  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[i]) ? CRC_POLY : 32'h0000_0000);
    end
    return c[31:26];
  endfunction : hidx
  function automatic logic exp_pass(input mrf_filter_ctrl_t f, input logic [47:0] da);
    logic [5:0] x;
    logic hh;
    x = hidx(da);
    hh = x[5] ? hash_table_high[x[4:0]] : hash_table_low[x[4:0]];
    if (f.promiscuous_enable && !f.inverse_filter_enable) return 1'b1;
    if (f.inverse_filter_enable) begin
      return (f == 5'b00100) ? (da != station_addr) : (da == station_addr);
    end
    if (f.pass_all_multicast && da[0]) return 1'b1;
    if (f.hash_only_enable && f.hash_perfect_enable) return hh;
    if (f.hash_perfect_enable && !f.pass_all_multicast) begin
      return da[0] ? hh : (da == station_addr);
    end
    return da == station_addr;
  endfunction : exp_pass
  task automatic rx_frame(input logic [47:0] da, input logic [15:0] tag, input int len,
                          input logic exp);
    int n;
    int r;
    n = frames;
    r = rejects;
    for (int i = 0; i < len; i++) phy.frm[i] = 8'(i);
    for (int k = 0; k < 6; k++) phy.frm[k] = da[8*k +: 8];
    phy.frm[12] = tag[15:8];
    phy.frm[13] = tag[7:0];
    phy.send(len, 1'b0);
    for (int t = 0; t < 40 && frames == n; t++) @(negedge clk_sys);
    if (frames == n) begin
      num_errors++;
      summarize();
    end
    chk(32'(last_good), 32'(exp));
    chk(32'(rejects - r), 32'(!exp));
  endtask : rx_frame
  task automatic tx_frame(input logic [15:0] tag);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk_sys);
      tx_busy = 1'b1;
      tx_byte_valid = 1'b1;
      tx_sof = (i == 0);
      tx_byte = (i == 12) ? tag[15:8] : ((i == 13) ? tag[7:0] : 8'(i));
    end
    @(negedge clk_sys);
    tx_byte_valid = 1'b0;
    tx_busy = 1'b0;
    tx_byte = ~tx_byte;
  endtask : tx_frame
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end
  initial begin
    modes = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h08, 5'h1B, 5'h10, 5'h11, 5'h13, 5'h02, 5'h0C};
    das = '{48'h5544_3322_1100, 48'h6655_4433_2202, 48'h0C0B_0A09_0801, 48'hFFFF_FFFF_FFFF};
    tags = '{16'h0800, vlan_tag_one, vlan_tag_two};
    // one unicast and one multicast hit so hash and perfect verdicts differ
    {hash_table_high, hash_table_low} = (64'h1 << hidx(das[1])) | (64'h1 << hidx(das[2]));
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    chk(32'(rx_max_len), 32'(MAX_LEN_PLAIN));
    chk(32'(rx_out_valid), 32'h0000_0000);
    for (int m = 0; m < 11; m++) begin
      filter_ctrl = modes[m];
      for (int d = 0; d < 4; d++) begin
        rx_frame(das[d], 16'h0800, 20, exp_pass(modes[m], das[d]));
      end
    end
    filter_ctrl = '0;
    rx_frame(station_addr, vlan_tag_one, 1522, 1'b1);
    chk(32'(rx_vlan_level), 32'(MRF_VLAN_ONE));
    rx_frame(station_addr, vlan_tag_two, 1523, 1'b0);
    chk(32'(rx_vlan_level), 32'(MRF_VLAN_TWO));
    rx_frame(station_addr, 16'h0800, 1518, 1'b1);
    rx_frame(station_addr, 16'h0800, 1519, 1'b0);
    for (int g = 0; g < 3; g++) begin
      tx_frame(tags[g]);
      chk(32'(tx_vlan_level), g);
      chk(32'(tx_max_len), (g == 0) ? 32'(MAX_LEN_PLAIN) : 32'(MAX_LEN_VLAN));
    end
    half_duplex = 1'b1;
    rx_out_ready = 1'b0;
    tx_busy = 1'b1;
    phy.send(4, 1'b0);
    // tx ends on the edge that takes a start byte: that frame and its tail must not be jammed
    fork
      phy.send(2, 1'b0);
      begin
        @(negedge clk_sys);
        tx_busy = 1'b0;
      end
    join
    chk(32'(jam_active), 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
    chk(32'(jam_active), 32'h0000_0000);
    phy.send(3, 1'b1);
    repeat (5) @(negedge clk_sys);
    chk(32'(jam_active), 32'h0000_0001);
    phy.drop();
    @(negedge clk_sys);
    chk(32'(jam_active), 32'h0000_0000);
    half_duplex = 1'b0;
    rx_out_ready = 1'b1;
    for (int t = 0; t < 20 && rx_out_valid; t++) @(negedge clk_sys);
    chk(32'(rx_out_valid), 32'h0000_0000);
    summarize();
  end
endmodule : mrf_rx_filter_tb_top
